// ==== ccsp_clock_ctrl.sv ====
/*
 * ccsp_clock_ctrl: cpu clock source select, fast clock divider, high and low prescalers.
 * assumes: one 50 MHz ref_clk; oscillator and reset pins are asynchronous and slower than
 * ref_clk/4; every generated clock enable leaves as a one-cycle pulse on ref_clk, lp_msb_q as a registered level.
 */
// How it works
// (RULE1) power-up, external reset pulse and leaving sleep select the rc oscillator.
// (RULE2) select 0 runs cpu on fastest clock; 1 on crystal or 32 kHz tap.
// (RULE3) source changes never make glitches or shortened cpu clock pulses.
// (RULE4) all enables off stops everything; crystal-only feeds cpu and low prescaler.
// (RULE5) rc-only and external use tap for select 1; rc plus crystal uses crystal.
// (RULE6) software keeps rc above 100 kHz while the crystal is enabled.
// (RULE7) fast cpu clock is divided by 1, 2, 4, 8 or 16.
// (RULE8) software selects new source first, then stops the old one separately.
// (RULE9) high prescaler has 8 binary stages, low prescaler 15.
// (RULE10) high prescaler runs only from rc or external, when either is enabled.
// (RULE11) low prescaler takes crystal directly if crystal on and external off.
// (RULE12) writing low prescaler clear zeroes the low prescaler synchronously.
// (RULE13) setting crystal enable also clears the low prescaler.
// (RULE14) global reset clears both prescaler chains asynchronously.
// (RULE15) crystal starting flag stays set for 32768 crystal cycles after enabling.
// (RULE16) without crystal, decoder picks the high prescaler tap nearest 32 kHz.
// (RULE17) decoder code is range, coarse trim and fine trim bits 5 to 3.
// (RULE18) decoder maps codes onto taps from undivided to divide by 128.
// (RULE19) with external clock, software sets trim to match half external frequency.
// (RULE20) external clock is halved internally before use.
// (RULE21) reset, external reset pulse and sleep clear crystal enable, set starting flag.
// (RULE22) fast source is rc, or halved external clock when external is enabled.
module ccsp_clock_ctrl
    import ccsp_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // oscillator and reset pins
    input  wire logic              rc_osc_in,
    input  wire logic              xtal_osc_in,
    input  wire logic              ext_clk_in,
    input  wire logic              external_reset_pin_n,
    // power control
    input  wire logic              sleep_req,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata_q,
    // generated clock enables and low prescaler msb level
    output logic                   cpu_clk_en_q,
    output logic                   hp_clk_en_q,
    output logic                   lp_clk_en_q,
    output logic                   lp_msb_q
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages 2 and 3 agree
    logic [2:0]        sync_q [SYNC_N];
    logic [SYNC_N-1:0] lvl_q;
    logic [SYNC_N-1:0] rise;
    wire  [SYNC_N-1:0] pin_raw = {external_reset_pin_n, ext_clk_in, xtal_osc_in, rc_osc_in};

    for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                // reset to the pin's idle level, else a false reset pulse follows
                sync_q[g] <= (g == 3) ? 3'h7 : 3'h0;
                lvl_q[g]  <= (g == 3);
            end else begin
                sync_q[g] <= {sync_q[g][1:0], pin_raw[g]};
                if (sync_q[g][1] == sync_q[g][2]) begin
                    lvl_q[g] <= sync_q[g][2];
                end
            end
        end
        assign rise[g] = (sync_q[g][1] == sync_q[g][2]) && sync_q[g][2] && !lvl_q[g];
    end

    wire rc_tick   = rise[0];
    wire xtal_tick = rise[1];
    wire ext_rise  = rise[2];
    wire pin_rst   = !lvl_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic       cpu_sel_q, rc_en_q, xtal_en_q, ext_en_q, xtal_strt_q, sleep_q;
    logic [4:0] trim_a_q;
    logic [5:0] trim_b_q;
    logic [2:0] cpu_div_q;
    logic [14:0] xs_cnt_q;

    wire wr_cfg   = reg_wr && (reg_addr == OFS_CLK_CFG);
    wire lp_clr   = reg_wr && (reg_addr == OFS_PRE_CTL) && reg_wdata[BIT_LP_CLEAR];
    wire xtal_set = wr_cfg && reg_wdata[BIT_XTAL_EN] && !xtal_en_q && !pin_rst && !sleep_req && !sleep_q;
    wire xtal_dir = xtal_en_q && !ext_en_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_req;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_sel_q <= 1'b0;
            rc_en_q   <= 1'b1; // (RULE1)
            xtal_en_q <= 1'b0;
            ext_en_q  <= 1'b0;
        end else if (pin_rst) begin
            cpu_sel_q <= 1'b0;
            rc_en_q   <= 1'b1; // (RULE1)
            xtal_en_q <= 1'b0; // (RULE21)
            ext_en_q  <= 1'b0;
        end else if (sleep_req) begin
            cpu_sel_q <= 1'b0;
            rc_en_q   <= 1'b0; // (RULE4)
            xtal_en_q <= 1'b0; // (RULE21)
            ext_en_q  <= 1'b0;
        end else if (sleep_q) begin
            rc_en_q   <= 1'b1; // (RULE1)
        end else if (wr_cfg) begin
            cpu_sel_q <= reg_wdata[BIT_CPU_SEL];
            rc_en_q   <= reg_wdata[BIT_RC_EN];
            xtal_en_q <= reg_wdata[BIT_XTAL_EN];
            ext_en_q  <= reg_wdata[BIT_EXT_EN];
        end
    end

    // start phase: cleared after the 32768th crystal edge since enabling
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            xtal_strt_q <= 1'b1;
            xs_cnt_q    <= '0;
        end else if (pin_rst || sleep_req || xtal_set) begin
            xtal_strt_q <= 1'b1; // (RULE21)
            xs_cnt_q    <= '0;
        end else if (xtal_en_q && xtal_strt_q && xtal_tick) begin
            xs_cnt_q    <= xs_cnt_q + 15'h1;
            if (xs_cnt_q == XTAL_START_LAST) begin
                xtal_strt_q <= 1'b0; // (RULE15)
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_a_q  <= RST_TRIM_A;
            trim_b_q  <= RST_TRIM_B;
            cpu_div_q <= RST_CPU_DIV;
        end else if (reg_wr) begin
            if (reg_addr == OFS_TRIM_A) trim_a_q <= reg_wdata[4:0];
            if (reg_addr == OFS_TRIM_B) trim_b_q <= reg_wdata[5:0];
            if (reg_addr == OFS_CPU_DIV) cpu_div_q <= reg_wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fast source and high prescaler
    logic                 ext_ph_q;
    logic [HP_STAGES-1:0] hp_q;
    logic [3:0]           cdiv_q;
    logic [2:0]           tap;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_ph_q <= 1'b0;
        end else if (!ext_en_q) begin
            ext_ph_q <= 1'b0;
        end else if (ext_rise) begin
            ext_ph_q <= !ext_ph_q; // (RULE20)
        end
    end

    // every second external edge gives one fast tick
    wire fast_tick = ext_en_q ? (ext_rise && ext_ph_q) : (rc_en_q && rc_tick); // (RULE22)
    wire hp_run    = rc_en_q || ext_en_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hp_q <= '0; // (RULE14)
        end else if (hp_run && fast_tick) begin
            hp_q <= hp_q + 1'b1; // (RULE9) (RULE10)
        end
    end

    ccsp_tap_decoder u_tap_dec (
        .code ({1'b0, trim_a_q[BIT_RANGE], trim_a_q[3:0], trim_b_q[5:3]}), // (RULE17)
        .tap  (tap)
    );

    wire [HP_STAGES-1:0] tmask    = HP_STAGES'((9'h1 << tap) - 9'h1);
    wire                 tap_tick = hp_run && fast_tick && ((hp_q & tmask) == tmask); // (RULE16)

    // cpu fast divider shares the fast tick so its pulses are whole source cycles
    wire [2:0] div_eff = (cpu_div_q > CPU_DIV_MAX) ? CPU_DIV_MAX : cpu_div_q;
    wire [3:0] dmask   = 4'((5'h1 << div_eff) - 5'h1);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cdiv_q <= '0;
        end else if (fast_tick) begin
            cdiv_q <= cdiv_q + 4'h1;
        end
    end

    wire fast_cpu_tick = fast_tick && ((cdiv_q & dmask) == dmask); // (RULE7)

    ////////////////////////////////////////////////////////////////////////////
    // low prescaler
    logic [LP_STAGES-1:0] lp_q;
    wire lp_tick = xtal_dir ? xtal_tick : tap_tick; // (RULE11)

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lp_q <= '0; // (RULE14)
        end else if (lp_clr || xtal_set) begin
            lp_q <= '0; // (RULE12) (RULE13)
        end else if (lp_tick) begin
            lp_q <= lp_q + 1'b1; // (RULE9)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu clock select; every candidate is a single-cycle pulse, so a switch
    // between two pulses cannot cut one short or make a runt
    logic cpu_tick;
    always_comb begin
        if (!rc_en_q && !ext_en_q) begin
            cpu_tick = xtal_en_q && xtal_tick; // (RULE4)
        end else if (!cpu_sel_q) begin
            cpu_tick = fast_cpu_tick; // (RULE2) (RULE5)
        end else begin
            cpu_tick = xtal_dir ? xtal_tick : tap_tick; // (RULE2) (RULE5)
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clk_en_q <= 1'b0;
            hp_clk_en_q  <= 1'b0;
            lp_clk_en_q  <= 1'b0;
            lp_msb_q     <= 1'b0;
        end else begin
            cpu_clk_en_q <= cpu_tick; // (RULE3)
            hp_clk_en_q  <= hp_run && fast_tick;
            lp_clk_en_q  <= lp_tick;
            lp_msb_q     <= lp_q[LP_STAGES-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read: data stand only in the cycle after the strobe
    logic [DATA_W-1:0] rd_val;
    always_comb begin
        case (reg_addr)
            OFS_CLK_CFG: rd_val = {3'h0, xtal_strt_q, ext_en_q, xtal_en_q, rc_en_q, cpu_sel_q};
            OFS_TRIM_A:  rd_val = {3'h0, trim_a_q};
            OFS_TRIM_B:  rd_val = {2'h0, trim_b_q};
            OFS_CPU_DIV: rd_val = {5'h0, cpu_div_q};
            OFS_HP_VAL:  rd_val = hp_q;
            OFS_LP_LO:   rd_val = lp_q[7:0];
            OFS_LP_HI:   rd_val = {1'b0, lp_q[14:8]};
            default:     rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rd ? rd_val : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_sleep_off;
        (!rc_en_q && !ext_en_q && !xtal_en_q) |=> !cpu_clk_en_q && !lp_clk_en_q;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("clock pulse while all sources off"); // (RULE4)

    property p_lp_clear;
        lp_clr |=> (lp_q == '0);
    endproperty
    a_lp_clear: assert property (p_lp_clear) else $error("low prescaler not cleared"); // (RULE12)

    property p_xtal_clear;
        xtal_set |=> (lp_q == '0) && xtal_en_q && xtal_strt_q;
    endproperty
    a_xtal_clear: assert property (p_xtal_clear) else $error("crystal enable did not clear"); // (RULE13)

    property p_hp_stop;
        (!rc_en_q && !ext_en_q) |=> $stable(hp_q);
    endproperty
    a_hp_stop: assert property (p_hp_stop) else $error("high prescaler ran without source"); // (RULE10)

    property p_pin_rst;
        pin_rst |=> rc_en_q && !xtal_en_q && xtal_strt_q && !cpu_sel_q;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("reset pin did not select rc"); // (RULE1)

    property p_sel_xtal;
        (cpu_sel_q && xtal_dir && rc_en_q && xtal_tick) |=> cpu_clk_en_q;
    endproperty
    a_sel_xtal: assert property (p_sel_xtal) else $error("cpu not on crystal"); // (RULE2)

    property p_start_end;
        (xtal_en_q && xtal_strt_q && xtal_tick && xs_cnt_q == XTAL_START_LAST
         && !pin_rst && !sleep_req && !xtal_set) |=> !xtal_strt_q;
    endproperty
    a_start_end: assert property (p_start_end) else $error("starting flag not cleared"); // (RULE15)

    property p_lp_xtal;
        (xtal_dir && xtal_tick && !lp_clr) |=> lp_clk_en_q ##0 (lp_q == $past(lp_q) + 1'b1);
    endproperty
    a_lp_xtal: assert property (p_lp_xtal) else $error("low prescaler missed crystal edge"); // (RULE11)

    property p_ext_half;
        (ext_en_q && ext_rise && !ext_ph_q) |=> ##0 !hp_clk_en_q;
    endproperty
    a_ext_half: assert property (p_ext_half) else $error("external clock not halved"); // (RULE20)
endmodule : ccsp_clock_ctrl

// ==== ccsp_pkg.sv ====
/*
 * ccsp_pkg: shared constants for the cpu clock select and prescaler block.
 * assumes: included by the top module and the tap decoder; 8-bit register bus.
 */
package ccsp_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 3;
    localparam int          HP_STAGES     = 8;
    localparam int          LP_STAGES     = 15;
    localparam int          SYNC_N        = 4;
    // register offsets
    localparam logic [2:0]  OFS_CLK_CFG   = 3'h0;
    localparam logic [2:0]  OFS_PRE_CTL   = 3'h1;
    localparam logic [2:0]  OFS_TRIM_A    = 3'h2;
    localparam logic [2:0]  OFS_TRIM_B    = 3'h3;
    localparam logic [2:0]  OFS_CPU_DIV   = 3'h4;
    localparam logic [2:0]  OFS_HP_VAL    = 3'h5;
    localparam logic [2:0]  OFS_LP_LO     = 3'h6;
    localparam logic [2:0]  OFS_LP_HI     = 3'h7;
    // clock_config_reg fields
    localparam int          BIT_CPU_SEL   = 0;
    localparam int          BIT_RC_EN     = 1;
    localparam int          BIT_XTAL_EN   = 2;
    localparam int          BIT_EXT_EN    = 3;
    localparam int          BIT_XTAL_STRT = 4;
    // prescaler_control_reg field
    localparam int          BIT_LP_CLEAR  = 0;
    // osc_trim_reg_a fields
    localparam int          BIT_RANGE     = 4;
    // reset values and the cpu divider limit
    localparam logic [4:0]  RST_TRIM_A    = 5'h01;
    localparam logic [5:0]  RST_TRIM_B    = 6'h00;
    localparam logic [2:0]  RST_CPU_DIV   = 3'h0;
    localparam logic [2:0]  CPU_DIV_MAX   = 3'h4;
    // last crystal cycle count of the start phase, one less than its length
    localparam logic [14:0] XTAL_START_LAST = 15'h7fff;
endpackage : ccsp_pkg

// ==== ccsp_tap_decoder.sv ====
/*
 * ccsp_tap_decoder: trim code to high prescaler tap index (0 = undivided, 7 = /128).
 * assumes: code is a zero bit, then range & coarse(3:0) & fine(5:3); output is combinational.
 */
module ccsp_tap_decoder
    import ccsp_pkg::*;
(
    // trim code
    input  wire logic [8:0] code,
    // selected tap
    output logic      [2:0] tap
);
    localparam int N = 52;
    // upper bound of each contiguous code range, ascending
    localparam logic [8:0] BND [N] = '{
        9'h004, 9'h00c, 9'h00f, 9'h010, 9'h016, 9'h017, 9'h01c, 9'h01f,
        9'h022, 9'h027, 9'h028, 9'h02e, 9'h02f, 9'h035, 9'h037, 9'h03c,
        9'h03f, 9'h043, 9'h047, 9'h04a, 9'h04f, 9'h051, 9'h057, 9'h058,
        9'h05e, 9'h05f, 9'h066, 9'h067, 9'h06d, 9'h06f, 9'h074, 9'h077,
        9'h07c, 9'h07f, 9'h082, 9'h08a, 9'h094, 9'h097, 9'h09a, 9'h09f,
        9'h0a0, 9'h0a6, 9'h0a7, 9'h0ac, 9'h0af, 9'h0b3, 9'h0b7, 9'h0ba,
        9'h0bf, 9'h0c1, 9'h0c7, 9'h0c8};
    // tap for each range above; codes beyond the last bound give /128
    localparam logic [2:0] TAP [N] = '{
        3'h0, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3,
        3'h2, 3'h3, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h3,
        3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h3,
        3'h4, 3'h5, 3'h4, 3'h5, 3'h4, 3'h5, 3'h4, 3'h5,
        3'h4, 3'h5, 3'h3, 3'h4, 3'h5, 3'h6, 3'h5, 3'h6,
        3'h5, 3'h6, 3'h7, 3'h6, 3'h7, 3'h6, 3'h7, 3'h6,
        3'h7, 3'h6, 3'h7, 3'h6};

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        tap = 3'h7; // (RULE18)
        for (int i = N - 1; i >= 0; i--) begin
            if (code <= BND[i]) begin
                tap = TAP[i]; // (RULE16) (RULE18)
            end
        end
    end
endmodule : ccsp_tap_decoder

// ==== ccsp_osc_model.sv ====
/*
 * ccsp_osc_model: oscillator pins in front of the clock block and a counter of its clock enables.
 * assumes: ref_clk runs; pins move only inside a burst and stand low between bursts.
 */
module ccsp_osc_model (
    // clock
    input  wire logic ref_clk,
    // enables from the block
    input  wire logic cpu_clk_en_q,
    input  wire logic hp_clk_en_q,
    input  wire logic lp_clk_en_q,
    // oscillator pins
    output logic      rc_osc_in,
    output logic      xtal_osc_in,
    output logic      ext_clk_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int n_cpu;
    int n_hp;
    int n_lp;

    initial begin
        rc_osc_in = 1'b0;
        xtal_osc_in = 1'b0;
        ext_clk_in = 1'b0;
    end

    always @(posedge ref_clk) begin
        n_cpu += int'(cpu_clk_en_q === 1'b1);
        n_hp += int'(hp_clk_en_q === 1'b1);
        n_lp += int'(lp_clk_en_q === 1'b1);
    end

    task automatic clear_counts();
        n_cpu = 0;
        n_hp = 0;
        n_lp = 0;
    endtask : clear_counts

    ////////////////////////////////////////////////////////////////////////////////
    // 10-cycle pin period: rc at 5 MHz stays far above 100 kHz with the crystal on,
    // and every pin stays below a quarter of ref_clk so no edge is lost
    task automatic burst(input int pin, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (pin == 0) rc_osc_in <= 1'b1;
            else if (pin == 1) xtal_osc_in <= 1'b1;
            else ext_clk_in <= 1'b1;
            repeat (5) @(posedge ref_clk);
            rc_osc_in <= 1'b0;
            xtal_osc_in <= 1'b0;
            ext_clk_in <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : burst
endmodule : ccsp_osc_model

// ==== ccsp_clock_ctrl_tb.sv ====
/*
 * ccsp_clock_ctrl_tb: register and pin scenarios for the clock select and prescaler block.
 * assumes: ccsp_pkg, ccsp_clock_ctrl and ccsp_osc_model compiled before it.
 */
module ccsp_clock_ctrl_tb import ccsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk;
    logic              arst_n;
    logic              external_reset_pin_n;
    logic              sleep_req;
    logic              reg_wr;
    logic              reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata_q;
    logic              rc_osc_in;
    logic              xtal_osc_in;
    logic              ext_clk_in;
    logic              cpu_clk_en_q;
    logic              hp_clk_en_q;
    logic              lp_clk_en_q;
    logic              lp_msb_q;
    int                fails;
    int                n_compared;
    int                cycles;
    // trim code table: reg a, reg b, expected tap
    logic [7:0]        trim_a [9] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h05, 8'h0b, 8'h12, 8'h1f, 8'h00};
    logic [7:0]        trim_b [9] = '{8'h00, 8'h00, 8'h28, 8'h38, 8'h38, 8'h38, 8'h28, 8'h3f, 8'h27};
    int                tap    [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 0};

    ccsp_clock_ctrl u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .rc_osc_in(rc_osc_in),
        .xtal_osc_in(xtal_osc_in), .ext_clk_in(ext_clk_in), .external_reset_pin_n(external_reset_pin_n),
        .sleep_req(sleep_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cpu_clk_en_q(cpu_clk_en_q),
        .hp_clk_en_q(hp_clk_en_q), .lp_clk_en_q(lp_clk_en_q), .lp_msb_q(lp_msb_q));

    ccsp_osc_model u_osc (.ref_clk(ref_clk), .cpu_clk_en_q(cpu_clk_en_q), .hp_clk_en_q(hp_clk_en_q),
        .lp_clk_en_q(lp_clk_en_q), .rc_osc_in(rc_osc_in), .xtal_osc_in(xtal_osc_in),
        .ext_clk_in(ext_clk_in));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // the whole run needs about 29k cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 50000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_cnt(input string nm, input int e, input int g, input int tol);
        n_compared++;
        if (g < e - tol || g > e + tol) begin
            fails++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cnt

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg(nm, e, reg_rdata_q);
    endtask : rd_chk

    // n pin edges, then a drain wait so the synchroniser tail is counted too
    task automatic run(input int pin, input int n, input int c, input int h, input int l, input int tol);
        #1;
        u_osc.clear_counts();
        u_osc.burst(pin, n);
        repeat (10) @(posedge ref_clk);
        #1;
        chk_cnt("cpu", c, u_osc.n_cpu, tol);
        chk_cnt("hp", h, u_osc.n_hp, 0);
        chk_cnt("lp", l, u_osc.n_lp, 0);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        external_reset_pin_n = 1'b1;
        sleep_req = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk("cfg", OFS_CLK_CFG, 8'h12);
        rd_chk("trim_a", OFS_TRIM_A, 8'h01);
        rd_chk("trim_b", OFS_TRIM_B, 8'h00);
        rd_chk("cpu_div", OFS_CPU_DIV, 8'h00);
        rd_chk("hp_val", OFS_HP_VAL, 8'h00);
        for (int d = 0; d < 5; d++) begin
            wr(OFS_CPU_DIV, 8'(d));
            run(0, 64, 64 >> d, 64, 32, (d == 0) ? 0 : 1);
        end
        wr(OFS_CPU_DIV, 8'h00);
        wr(OFS_HP_VAL, 8'hff);
        rd_chk("hp_val", OFS_HP_VAL, 8'h40);
        rd_chk("lp_lo", OFS_LP_LO, 8'ha0);
        // select 1 in rc-only mode: cpu and low prescaler follow the decoded tap
        wr(OFS_CLK_CFG, 8'h03);
        for (int i = 0; i < 9; i++) begin
            wr(OFS_TRIM_A, trim_a[i]);
            wr(OFS_TRIM_B, trim_b[i]);
            run(0, 256, 256 >> tap[i], 256, 256 >> tap[i], 0);
        end
        rd_chk("lp_lo", OFS_LP_LO, 8'h9e);
        rd_chk("lp_hi", OFS_LP_HI, 8'h03);
        wr(OFS_PRE_CTL, 8'h01);
        rd_chk("lp_lo", OFS_LP_LO, 8'h00);
        rd_chk("pre_ctl", OFS_PRE_CTL, 8'h00);
        wr(OFS_TRIM_A, 8'h01);
        wr(OFS_TRIM_B, 8'h00);
        run(0, 4, 2, 4, 2, 0);
        // crystal on: select first, then stop rc in a second write
        wr(OFS_CLK_CFG, 8'h07);
        rd_chk("lp_lo", OFS_LP_LO, 8'h00);
        run(1, 20, 20, 0, 20, 0);
        run(0, 16, 0, 16, 0, 0);
        wr(OFS_CLK_CFG, 8'h05);
        run(0, 16, 0, 0, 0, 0);
        run(1, 20, 20, 0, 20, 0);
        rd_chk("cfg", OFS_CLK_CFG, 8'h15);
        wr(OFS_CLK_CFG, 8'h04);
        run(1, 8, 8, 0, 8, 0);
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd_chk("cfg", OFS_CLK_CFG, 8'h10);
        run(0, 16, 0, 0, 0, 0);
        run(1, 8, 0, 0, 0, 0);
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd_chk("cfg", OFS_CLK_CFG, 8'h12);
        wr(OFS_CLK_CFG, 8'h0b);
        external_reset_pin_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd_chk("cfg", OFS_CLK_CFG, 8'h12);
        external_reset_pin_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        // trim left at its default, matched to the halved external rate
        wr(OFS_CLK_CFG, 8'h0a);
        run(2, 64, 32, 32, 16, 0);
        wr(OFS_CLK_CFG, 8'h0b);
        run(2, 64, 16, 32, 16, 0);
        wr(OFS_CLK_CFG, 8'h0f);
        run(1, 8, 0, 0, 0, 0);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk("hp_val", OFS_HP_VAL, 8'h00);
        rd_chk("lp_lo", OFS_LP_LO, 8'h00);
        chk_reg("lp_msb", 8'h00, {7'h0, lp_msb_q});
        end_sim();
    end
endmodule : ccsp_clock_ctrl_tb
